// *** hdl/pwr_mode_pkg.sv ***
package pwr_mode_pkg;
  // ***************************************************
  // Register addresses (visible on every page)
  // ***************************************************
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_EXT_PRIO_ONE = 8'hF6;
  localparam logic [7:0] ADDR_EXT_PRIO_TWO = 8'hF7;
  // ***************************************************
  // Reset values and field positions
  // ***************************************************
  localparam logic [7:0] RESET_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RESET_EXT_PRIO = 8'h00;
  localparam logic [7:0] PRIO_WRITE_MASK = 8'h7F;
  localparam int IDLE_SELECT_BIT = 0;
  localparam int STOP_SELECT_BIT = 1;
  // First priority register fields
  localparam int COMPARATOR2_PRIORITY = 6;
  localparam int COMPARATOR1_PRIORITY = 5;
  localparam int COMPARATOR0_PRIORITY = 4;
  localparam int COUNTER_ARRAY_PRIORITY = 3;
  localparam int CONV0_WINDOW_PRIORITY = 2;
  localparam int TWO_WIRE_BUS_PRIORITY = 1;
  localparam int SERIAL_PERIPH_PRIORITY = 0;
  // Second priority register fields
  localparam int UART_SECOND_PRIORITY = 6;
  localparam int CAN_PRIORITY = 5;
  localparam int CONV2_DONE_PRIORITY = 4;
  localparam int CONV2_WINDOW_PRIORITY = 3;
  localparam int TIMER_FOUR_PRIORITY = 2;
  localparam int CONV0_DONE_PRIORITY = 1;
  localparam int TIMER_THREE_PRIORITY = 0;
  // Number of extended sources (7 per register)
  localparam int NUM_SRC = 14;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MCD_TIMEOUT_US = 100;
  localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  // ***************************************************
  // Types
  // ***************************************************
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_STOP} pm_state_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// *** hdl/core_power_mode.sv ***
// Behaviour
// - Priority bit 0 low, 1 high
// - First register: comparators, array, window, bus, serial
// - Second register: uart, can, conv2, timers, conv0
// - Timer three bit selects low/high normally
// - Idle select write halts processor after instruction
// - Idle gates only processor clock
// - Enabled interrupt or reset ends idle
// - Wake services interrupt, then resumes next instruction
// - Reset ends modes; fetch from zero
// - Watchdog keeps counting, resets out of idle
// - Stop select halts processor and oscillator
// - Stop ignores interrupts; only reset ends it
// - Missing clock detector timeout resets stop
// - Mode bits read zero; writing zero nothing
// - Priority registers at F6/F7, reset zero
// - Power control at 87, reset zero
`timescale 1ns/1ns
`default_nettype none
module core_power_mode #(
  parameter int MCD_CYCLES = pwr_mode_pkg::MCD_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire pwr_mode_pkg::reg_req_t regReq,
  input wire logic instrDone,
  input wire logic [13:0] irqReq,
  input wire logic [13:0] irqEnable,
  input wire logic retiDone,
  input wire logic extReset,
  input wire logic watchdogEn,
  input wire logic watchdogOverflow,
  input wire logic mcdEnable,
  output logic [7:0] regRdata,
  output logic cpuClkGate,
  output logic oscStop,
  output logic periphClkEn,
  output logic irqPending,
  output logic [3:0] irqIndex,
  output logic irqHigh,
  output logic internalReset,
  output logic [15:0] fetchAddr,
  output logic [1:0] powerMode
);
  // ***************************************************
  // Input synchronisers for pins
  // ***************************************************
  logic extRstMeta; // First stage, read only by second
  logic extRstSync; // Clean reset pin level
  logic [13:0] irqMeta; // First stage of interrupt lines
  logic [13:0] irqSync; // Synchronised interrupt lines
  // Two-flop synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      extRstMeta <= 1'b0;
      extRstSync <= 1'b0;
      irqMeta <= 14'h0000;
      irqSync <= 14'h0000;
    end
    else if (clkEn)
    begin
      extRstMeta <= extReset;
      extRstSync <= extRstMeta;
      irqMeta <= irqReq;
      irqSync <= irqMeta;
    end
  end
  // ***************************************************
  // Registers
  // ***************************************************
  logic [7:0] prioOne; // First extended priority register
  logic [7:0] prioTwo; // Second extended priority register
  logic [7:0] next_prioOne;
  logic [7:0] next_prioTwo;
  logic wrPcon; // Write hits the power-control address
  logic reqIdle; // Idle requested by write
  logic reqStop; // Stop requested by write
  logic pendIdle; // Armed until instruction ends
  logic pendStop;
  logic next_pendIdle;
  logic next_pendStop;
  // Decode and next values of the register file
  always_comb
  begin
    wrPcon = regReq.wrEn && regReq.addr == pwr_mode_pkg::ADDR_POWER_CONTROL;
    // Only a one triggers a mode; zero writes ignored
    reqIdle = wrPcon && regReq.wdata[pwr_mode_pkg::IDLE_SELECT_BIT];
    reqStop = wrPcon && regReq.wdata[pwr_mode_pkg::STOP_SELECT_BIT];
    next_prioOne = prioOne;
    next_prioTwo = prioTwo;
    // Priority writes, reserved bit 7 kept zero
    if (regReq.wrEn && regReq.addr == pwr_mode_pkg::ADDR_EXT_PRIO_ONE)
      next_prioOne = regReq.wdata & pwr_mode_pkg::PRIO_WRITE_MASK;
    if (regReq.wrEn && regReq.addr == pwr_mode_pkg::ADDR_EXT_PRIO_TWO)
      next_prioTwo = regReq.wdata & pwr_mode_pkg::PRIO_WRITE_MASK;
    next_pendIdle = pendIdle | reqIdle;
    next_pendStop = pendStop | reqStop;
    if (instrDone)
    begin
      next_pendIdle = 1'b0;
      next_pendStop = 1'b0;
    end
  end
  // Register file storage, all cleared on reset
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      prioOne <= pwr_mode_pkg::RESET_EXT_PRIO;
      prioTwo <= pwr_mode_pkg::RESET_EXT_PRIO;
      pendIdle <= 1'b0;
      pendStop <= 1'b0;
    end
    else if (clkEn)
    begin
      prioOne <= next_prioOne;
      prioTwo <= next_prioTwo;
      pendIdle <= next_pendIdle;
      pendStop <= next_pendStop;
    end
  end
  // Read data: mode bits always read zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      regRdata <= 8'h00;
    else if (clkEn && regReq.rdEn)
    begin
      case (regReq.addr)
        pwr_mode_pkg::ADDR_POWER_CONTROL: regRdata <= 8'h00;
        pwr_mode_pkg::ADDR_EXT_PRIO_ONE: regRdata <= prioOne;
        pwr_mode_pkg::ADDR_EXT_PRIO_TWO: regRdata <= prioTwo;
        default: regRdata <= 8'h00;
      endcase
    end
  end
  // ***************************************************
  // Priority resolution
  // ***************************************************
  logic [13:0] prioVec; // One bit per source, 1 = high
  logic [13:0] active; // Requests that are enabled
  logic [13:0] isHigh; // Enabled and high priority
  logic [3:0] pickIdx; // Chosen source
  logic pickHigh;
  logic pickAny;
  logic [1:0] svcLevel; // Bit1 high handler, bit0 low handler
  logic [1:0] next_svcLevel;
  logic takeIrq; // Start servicing the chosen source
  pwr_mode_pkg::pm_state_t state; // Current power mode
  pwr_mode_pkg::pm_state_t next_state;
  genvar gi;
  // Source i maps to bit i of the first register, source i+7 to bit i of the second
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_map
      assign prioVec[gi] = prioOne[gi];
      assign prioVec[gi + 7] = prioTwo[gi];
    end
  endgenerate
  // Pick highest level request, lowest index first
  always_comb
  begin
    active = irqSync & irqEnable;
    isHigh = active & prioVec;
    pickIdx = 4'h0;
    pickHigh = 1'b0;
    pickAny = 1'b0;
    for (int i = 13; i >= 0; i--)
    begin
      if (active[i] && !isHigh[i] && isHigh == 14'h0000)
      begin
        pickIdx = 4'(i);
        pickAny = 1'b1;
      end
      if (isHigh[i])
      begin
        pickIdx = 4'(i);
        pickHigh = 1'b1;
        pickAny = 1'b1;
      end
    end
    // High preempts low; nothing preempts high
    takeIrq = pickAny && !svcLevel[1] && (pickHigh || !svcLevel[0]);
    next_svcLevel = svcLevel;
    if (retiDone)
    begin
      if (svcLevel[1])
        next_svcLevel[1] = 1'b0;
      else
        next_svcLevel[0] = 1'b0;
    end
    if (takeIrq && state != pwr_mode_pkg::PM_STOP)
    begin
      if (pickHigh)
        next_svcLevel[1] = 1'b1;
      else
        next_svcLevel[0] = 1'b1;
    end
  end
  // ***************************************************
  // Power-mode state machine
  // ***************************************************
  logic [16:0] mcdCount; // Missing-clock timer while stopped
  logic [16:0] next_mcdCount;
  logic mcdFire;
  logic rstAny; // Pin or watchdog reset, which ends any mode
  // Next mode
  always_comb
  begin
    next_state = state;
    next_mcdCount = 17'h00000;
    mcdFire = 1'b0;
    // Watchdog runs in idle and its overflow resets
    rstAny = extRstSync || (watchdogEn && watchdogOverflow);
    case (state)
      pwr_mode_pkg::PM_RUN:
        // Stop wins when both bits are set
        if (instrDone && (pendStop || reqStop))
          next_state = pwr_mode_pkg::PM_STOP;
        else if (instrDone && (pendIdle || reqIdle))
          next_state = pwr_mode_pkg::PM_IDLE;
      pwr_mode_pkg::PM_IDLE:
        // Enabled interrupt clears idle and resumes
        if (pickAny)
          next_state = pwr_mode_pkg::PM_RUN;
      pwr_mode_pkg::PM_STOP:
      begin
        // Interrupts ignored; detector counts only
        if (mcdEnable)
          next_mcdCount = mcdCount + 17'h00001;
        if (mcdEnable && mcdCount >= 17'(MCD_CYCLES - 1))
          mcdFire = 1'b1;
      end
      default: next_state = pwr_mode_pkg::PM_RUN;
    endcase
    if (rstAny || mcdFire)
    begin
      next_state = pwr_mode_pkg::PM_RUN;
      next_mcdCount = 17'h00000;
    end
  end
  // Mode and handler level registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state <= pwr_mode_pkg::PM_RUN;
      mcdCount <= 17'h00000;
      svcLevel <= 2'b00;
      internalReset <= 1'b0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      mcdCount <= next_mcdCount;
      svcLevel <= (rstAny || mcdFire) ? 2'b00 : next_svcLevel;
      internalReset <= rstAny || mcdFire;
    end
  end
  // ***************************************************
  // Outputs
  // ***************************************************
  // Idle gates CPU only; stop also stops oscillator
  always_comb
  begin
    cpuClkGate = state != pwr_mode_pkg::PM_RUN;
    oscStop = state == pwr_mode_pkg::PM_STOP;
    periphClkEn = state != pwr_mode_pkg::PM_STOP;
    irqPending = pickAny && takeIrq && state != pwr_mode_pkg::PM_STOP;
    irqIndex = pickIdx;
    irqHigh = pickHigh;
    fetchAddr = 16'h0000; // Reset vector
    powerMode = state;
  end
  // ***************************************************
  // Checks
  // ***************************************************
  property p_stop_wins;
    @(posedge ref_clk) disable iff (sys_rst)
    (clkEn && state == pwr_mode_pkg::PM_RUN && instrDone && reqStop &&
     !rstAny) |=> state == pwr_mode_pkg::PM_STOP;
  endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("no stop");
  property p_stop_no_irq;
    @(posedge ref_clk) disable iff (sys_rst)
    (clkEn && state == pwr_mode_pkg::PM_STOP && !rstAny && !mcdFire)
    |=> state == pwr_mode_pkg::PM_STOP;
  endproperty
  a_stop_no_irq: assert property (p_stop_no_irq) else $error("left");
  property p_idle_wake;
    @(posedge ref_clk) disable iff (sys_rst)
    (clkEn && state == pwr_mode_pkg::PM_IDLE && pickAny)
    |=> state == pwr_mode_pkg::PM_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle stuck");
  property p_rd_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    (clkEn && regReq.rdEn && regReq.addr == pwr_mode_pkg::ADDR_POWER_CONTROL)
    |=> regRdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("bits read");
  property p_idle_gate;
    @(posedge ref_clk) disable iff (sys_rst)
    state == pwr_mode_pkg::PM_IDLE |-> cpuClkGate && periphClkEn && !oscStop;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle clk");
  property p_no_preempt_high;
    @(posedge ref_clk) disable iff (sys_rst)
    irqPending |-> !svcLevel[1] && (irqHigh || !svcLevel[0]);
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high)
    else $error("preempt");
  property p_rst_ends;
    @(posedge ref_clk) disable iff (sys_rst)
    (clkEn && extRstSync) |=> state == pwr_mode_pkg::PM_RUN && internalReset;
  endproperty
  a_rst_ends: assert property (p_rst_ends) else $error("no reset");
  property p_prio_rsv;
    @(posedge ref_clk) disable iff (sys_rst)
    !prioOne[7] && !prioTwo[7];
  endproperty
  a_prio_rsv: assert property (p_prio_rsv) else $error("rsv set");
endmodule
`default_nettype wire

// *** dv/core_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
// Core side: finishes the writing instruction and returns from handlers
module core_partner (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pwr_mode_pkg::reg_req_t regReq,
  input wire logic irqPending,
  input wire logic [3:0] retiDelay,
  output logic instrDone,
  output var logic retiDone
);
  logic busy; // Handler in progress
  logic [3:0] cnt; // Cycles left in handler
  logic nested; // A higher handler interrupted a lower one
  // Write completes with its instruction; instrDone follows regReq.wrEn
  assign instrDone = regReq.wrEn;
  // Handler runs retiDelay+1 cycles, then returns
  always_ff @(posedge ref_clk)
  begin
    retiDone <= 1'b0;
    if (sys_rst)
    begin
      busy <= 1'b0;
      cnt <= 4'h0;
      nested <= 1'b0;
    end
    else if (irqPending && !busy)
    begin
      busy <= 1'b1;
      cnt <= retiDelay;
    end
    else if (irqPending)
    begin
      // Preempting handler; the outer one resumes after it returns
      nested <= 1'b1;
      cnt <= retiDelay;
    end
    else if (busy && cnt == 4'h0)
    begin
      busy <= nested;
      nested <= 1'b0;
      cnt <= retiDelay;
      retiDone <= 1'b1;
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
endmodule
`default_nettype wire

// *** dv/core_power_mode_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module core_power_mode_bench;
  localparam int MISSING_CLOCK_DETECTOR = 20; // Shortened detector timeout
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  pwr_mode_pkg::reg_req_t regReq = '0;
  logic [13:0] irqReq = 14'h0000;
  logic [13:0] irqEnable = 14'h0000;
  logic extReset = 1'b0;
  logic watchdogEn = 1'b0;
  logic watchdogOverflow = 1'b0;
  logic mcdEnable = 1'b0;
  logic instrDone, retiDone, cpuClkGate, oscStop, periphClkEn;
  logic irqPending, irqHigh, internalReset;
  logic [3:0] irqIndex;
  logic [7:0] regRdata;
  logic [15:0] fetchAddr;
  logic [1:0] powerMode;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  core_power_mode #(.MCD_CYCLES(MISSING_CLOCK_DETECTOR)) u_core_power_mode (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .clkEn(1'b1), .regReq(regReq),
    .instrDone(instrDone), .irqReq(irqReq), .irqEnable(irqEnable),
    .retiDone(retiDone), .extReset(extReset), .watchdogEn(watchdogEn),
    .watchdogOverflow(watchdogOverflow), .mcdEnable(mcdEnable),
    .regRdata(regRdata), .cpuClkGate(cpuClkGate), .oscStop(oscStop),
    .periphClkEn(periphClkEn), .irqPending(irqPending),
    .irqIndex(irqIndex), .irqHigh(irqHigh),
    .internalReset(internalReset), .fetchAddr(fetchAddr),
    .powerMode(powerMode));
  core_partner u_core_partner (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regReq(regReq), .irqPending(irqPending), .retiDelay(4'h2),
    .instrDone(instrDone), .retiDone(retiDone));
  always #5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic cmp(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register write, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    regReq = '0;
    @(negedge ref_clk);
  endtask
  // One register read; data is due one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    cmp("regRdata", {8'h00, exp}, {8'h00, regRdata});
    regReq = '0;
    @(negedge ref_clk);
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return irqPending === 1'b1;
      1: return internalReset === 1'b1;
      2: return retiDone === 1'b1;
      default: return powerMode === 2'(sel - 3);
    endcase
  endfunction
  // Bounded wait for an event; 3..5 mean run, idle, stop
  task automatic waitOn(input int sel, input int lim);
    int i;
    i = 0;
    while (!probe(sel) && i < lim)
    begin
      @(negedge ref_clk);
      i++;
    end
    cmp("event", 16'(sel), probe(sel) ? 16'(sel) : 16'hFFFF);
  endtask
  task automatic t_regs();
    rd(8'hF6, 8'h00);
    rd(8'hF7, 8'h00);
    rd(8'h87, 8'h00);
    wr(8'hF6, 8'hFF);
    rd(8'hF6, 8'h7F);
    wr(8'hF7, 8'hFF);
    rd(8'hF7, 8'h7F);
    rd(8'h55, 8'h00);
    wr(8'h87, 8'h00);
    cmp("powerMode", 16'h0000, {14'h0000, powerMode});
    cmp("cpuClkGate", 16'h0000, {15'h0000, cpuClkGate});
    cmp("oscStop", 16'h0000, {15'h0000, oscStop});
    rd(8'h87, 8'h00);
    wr(8'hF6, 8'h00);
    wr(8'hF7, 8'h00);
  endtask
  task automatic t_idle();
    irqEnable = 14'h0004;
    wr(8'h87, 8'h01);
    waitOn(4, 4);
    cmp("cpuClkGate", 16'h0001, {15'h0000, cpuClkGate});
    cmp("periphClkEn", 16'h0001, {15'h0000, periphClkEn});
    cmp("oscStop", 16'h0000, {15'h0000, oscStop});
    irqReq = 14'h0004;
    waitOn(0, 6);
    cmp("irqIndex", 16'h0002, {12'h000, irqIndex});
    irqReq = 14'h0000;
    waitOn(3, 3);
    waitOn(2, 10);
  endtask
  task automatic t_prio();
    wr(8'hF6, 8'h08);
    irqEnable = 14'h0009;
    irqReq = 14'h0009;
    waitOn(0, 6);
    cmp("irqIndex", 16'h0003, {12'h000, irqIndex});
    cmp("irqHigh", 16'h0001, {15'h0000, irqHigh});
    irqReq = 14'h0000;
    waitOn(2, 10);
    wr(8'hF6, 8'h00);
    wr(8'hF7, 8'h01);
    irqEnable = 14'h0082;
    irqReq = 14'h0082;
    waitOn(0, 6);
    cmp("irqIndex", 16'h0007, {12'h000, irqIndex});
    cmp("irqHigh", 16'h0001, {15'h0000, irqHigh});
    irqReq = 14'h0000;
    waitOn(2, 10);
    wr(8'hF7, 8'h00);
  endtask
  // Low handler running, then a high request preempts it
  task automatic t_preempt();
    wr(8'hF6, 8'h08);
    irqEnable = 14'h0009;
    irqReq = 14'h0001;
    waitOn(0, 6);
    cmp("irqHigh", 16'h0000, {15'h0000, irqHigh});
    @(negedge ref_clk);
    cmp("irqPending", 16'h0000, {15'h0000, irqPending});
    irqReq = 14'h0009;
    waitOn(0, 6);
    cmp("irqIndex", 16'h0003, {12'h000, irqIndex});
    cmp("irqHigh", 16'h0001, {15'h0000, irqHigh});
    irqReq = 14'h0000;
    waitOn(2, 10);
    @(negedge ref_clk);
    waitOn(2, 10);
    wr(8'hF6, 8'h00);
  endtask
  task automatic t_stop();
    irqEnable = 14'h0001;
    wr(8'h87, 8'h03);
    waitOn(5, 4);
    cmp("oscStop", 16'h0001, {15'h0000, oscStop});
    cmp("periphClkEn", 16'h0000, {15'h0000, periphClkEn});
    irqReq = 14'h0001;
    repeat (10) @(negedge ref_clk);
    cmp("powerMode", 16'h0002, {14'h0000, powerMode});
    cmp("irqPending", 16'h0000, {15'h0000, irqPending});
    irqReq = 14'h0000;
    irqEnable = 14'h0000;
    mcdEnable = 1'b1; // Kept off above so the stop outlasts it
    waitOn(1, MISSING_CLOCK_DETECTOR + 10);
    waitOn(3, 5);
    cmp("fetchAddr", 16'h0000, fetchAddr);
    mcdEnable = 1'b0;
    wr(8'h87, 8'h02);
    waitOn(5, 4);
    extReset = 1'b1;
    waitOn(3, 8);
    extReset = 1'b0;
    // Let the synchronised pin level drain before the next write
    repeat (3) @(negedge ref_clk);
    cmp("internalReset", 16'h0000, {15'h0000, internalReset});
  endtask
  task automatic t_dog();
    watchdogEn = 1'b1;
    wr(8'h87, 8'h01);
    waitOn(4, 4);
    watchdogOverflow = 1'b1;
    waitOn(1, 6);
    watchdogOverflow = 1'b0;
    waitOn(3, 5);
    watchdogEn = 1'b0;
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_regs();
    t_idle();
    t_prio();
    t_preempt();
    t_stop();
    t_dog();
    conclude();
  end
endmodule
`default_nettype wire
